/* File: inc/uifr_pkg.sv */
// constants and types of the uart interrupt, flow and fifo register bank
package uifr_pkg;

  // -------------------------------------------------------------------
  // register indices on the register port
  // -------------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 64;
  localparam logic [3:0] A_IER   = 4'h1;
  localparam logic [3:0] A_IIR   = 4'h2;  // read: id, write: fifo_control
  localparam logic [3:0] A_MCR   = 4'h4;
  localparam logic [3:0] A_TCR   = 4'h6;
  localparam logic [3:0] A_TLR   = 4'h7;
  localparam logic [3:0] A_TX_FIFO_SPACE_COUNT = 4'h8;
  localparam logic [3:0] A_DLL   = 4'hA;
  localparam logic [3:0] A_DLH   = 4'hB;
  localparam logic [3:0] A_EFR   = 4'hC;
  localparam logic [3:0] A_SECOND_STOP_CHAR = 4'hD;

  // -------------------------------------------------------------------
  // field positions, masks, reset values
  // -------------------------------------------------------------------
  localparam int EFR_CTS  = 7;
  localparam int EFR_RTS  = 6;
  localparam int EFR_SPC  = 5;
  localparam int EFR_ENH  = 4;
  localparam int MCR_TLEN = 2;
  localparam int MCR_RTS  = 1;
  localparam int FCR_EN   = 0;
  localparam int IER_RHR  = 0;
  localparam int IER_THR  = 1;
  localparam int IER_LSR  = 2;
  localparam int IER_MOD  = 3;
  localparam int IER_XOFF = 5;
  localparam int IER_RTSI = 6;
  localparam int IER_CTSI = 7;
  localparam logic [7:0] IER_PROT = 8'hF0;
  localparam logic [7:0] FCR_PROT = 8'h30;
  localparam logic [7:0] FCR_KEEP = 8'hF1;
  localparam logic [7:0] MCR_PROT = 8'hE4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] ONE16   = 16'h0001;

  // -------------------------------------------------------------------
  // interrupt identification codes, bit 0 low means pending
  // -------------------------------------------------------------------
  localparam logic [5:0] ID_LSR   = 6'h06;
  localparam logic [5:0] ID_RXTO  = 6'h0C;
  localparam logic [5:0] ID_RHR   = 6'h04;
  localparam logic [5:0] ID_THR   = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_XOFF  = 6'h10;
  localparam logic [5:0] ID_FLOW  = 6'h20;
  localparam logic [5:0] ID_NONE  = 6'h01;

  // -------------------------------------------------------------------
  // trigger levels chosen by fifo_control bits 7:6 and 5:4
  // -------------------------------------------------------------------
  localparam logic [6:0] FCR_RX_TRIG [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
  localparam logic [6:0] FCR_TX_TRIG [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
  localparam logic [6:0] RX_TRIG_NOFIFO = 7'h01;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] data;
  } uifr_req_t;

  typedef struct packed {
    logic lsr;
    logic rxto;
    logic receive_holding;
    logic transmit_holding;
    logic modem;
    logic xoff;
    logic flow;
  } uifr_src_t;

  typedef enum logic {
    RTS_GO   = 1'b0,
    RTS_HALT = 1'b1
  } uifr_rts_t;

endpackage : uifr_pkg

/* File: rtl/uifr_irq_prio.sv */
// fixed priority encoder of enabled interrupt sources
`timescale 1ns/100ps
`default_nettype none
module uifr_irq_prio (
  input  wire uifr_pkg::uifr_src_t src_in,
  output logic [5:0]               iid_out,
  output logic                     pend_out
);
  import uifr_pkg::*;

  // -------------------------------------------------------------------
  // highest level wins, one code reported
  // -------------------------------------------------------------------
  always_comb begin
    pend_out = |src_in;
    if (src_in.lsr) begin
      iid_out = ID_LSR;
    end else if (src_in.rxto) begin
      iid_out = ID_RXTO;
    end else if (src_in.receive_holding) begin
      iid_out = ID_RHR;
    end else if (src_in.transmit_holding) begin
      iid_out = ID_THR;
    end else if (src_in.modem) begin
      iid_out = ID_MODEM;
    end else if (src_in.xoff) begin
      iid_out = ID_XOFF;
    end else if (src_in.flow) begin
      iid_out = ID_FLOW;
    end else begin
      iid_out = ID_NONE;
    end
  end

endmodule : uifr_irq_prio
`default_nettype wire

/* File: rtl/uifr_regs.sv */
// uart interrupt id, flow control, divisor and fifo level registers
//
// Function
// [R1] read-only id register reports the one highest pending source
// [R2] id bits 7:6 mirror the fifo enable bit
// [R3] id bit 0 reads low while any interrupt is pending
// [R4] codes and levels for line error, timeout, receive data, transmit
// [R5] xoff or special char code 010000; cts/rts rise code 100000
// [R6] cts flow enable stops transmit while cts is high
// [R7] auto rts: high at halt level, low again at resume level
// [R8] special char match still stored, flags code 010000
// [R9] enhanced bit 4 write-enables protected enable, fifo, modem bits
// [R10] enhanced bits 3:0 select software flow control combination
// [R11] 16-bit divisor from two bytes divides the baud clock
// [R12] host writes divisor only before sleep mode is enabled
// [R13] flow thresholds hold 0 to 60 characters in steps of four
// [R14] flow thresholds writable only with enhanced bit and modem bit 2
// [R15] host keeps halt level above resume level; not checked
// [R16] trigger levels: receive in 7:4, transmit in 3:0, level/4
// [R17] trigger levels writable only with enhanced bit and modem bit 2
// [R18] zero trigger field falls back to fifo_control level, or to 1 (receive) and FIFO_DEPTH (transmit) with the fifo off
// [R19] host leaves fifo_control 7:6 at 00 when using trigger register
// [R20] transmit space register reads 0 to 64, bit 7 zero
// [R21] each source gated by an enable bit; timeout shares the receive data enable bit
// [R22] reported source stays until cleared, then next one shows
`timescale 1ns/100ps
`default_nettype none
module uifr_regs #(
  parameter int unsigned FIFO_DEPTH = uifr_pkg::FIFO_DEPTH
) (
  input  wire logic                clock_in,
  input  wire logic                arst_n_in,
  input  wire uifr_pkg::uifr_req_t reg_req_in,
  output logic [7:0]               rd_data_out,
  input  wire logic [6:0]          rx_fill_in,
  input  wire logic [6:0]          tx_space_in,
  input  wire logic                line_err_in,
  input  wire logic                rx_timeout_in,
  input  wire logic                rx_char_valid_in,
  input  wire logic [7:0]          rx_char_in,
  input  wire logic                xoff_rcvd_in,
  input  wire logic                tx_push_in,
  input  wire logic                msr_read_in,
  input  wire logic                cts_n_in,
  output logic                     rts_n_out,
  output logic                     tx_halt_out,
  output logic                     irq_n_out,
  output logic                     baud_tick_out,
  output logic [3:0]               sw_flow_sel_out
);
  import uifr_pkg::*;

  if (FIFO_DEPTH < 4 || FIFO_DEPTH > 64) begin : g_chk
    $error("FIFO_DEPTH must lie in 4..64");
  end

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic hit(input uifr_req_t r, input logic [3:0] a);
    hit = (r.addr == a);
  endfunction : hit

  function automatic logic [6:0] lvl(input logic [3:0] nib);
    lvl = {1'b0, nib, 2'b00};  // [R13] [R16]
  endfunction : lvl

  function automatic logic [7:0] prot_wr(input logic [7:0] old,
                                         input logic [7:0] nw,
                                         input logic [7:0] mask,
                                         input logic       en);
    prot_wr = en ? nw : ((old & mask) | (nw & ~mask));  // [R9]
  endfunction : prot_wr

  // -------------------------------------------------------------------
  // reset release
  // -------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // -------------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------------
  logic [7:0]  ier_ff;
  logic [7:0]  fcr_ff;
  logic [7:0]  mcr_ff;
  logic [7:0]  efr_ff;
  logic [7:0]  tcr_ff;
  logic [7:0]  tlr_ff;
  logic [7:0]  dll_ff;
  logic [7:0]  dlh_ff;
  logic [7:0]  second_stop_char_ff;
  logic [15:0] baud_cnt_ff;
  logic        thr_cond_ff;
  logic        thr_ff;
  logic        xoff_ff;
  logic        cts_ff;
  logic        cts_up_ff;
  logic        rts_up_ff;
  logic        dcts_ff;
  uifr_rts_t   rts_st_ff;
  uifr_rts_t   nxt_rts_st;
  logic        nxt_rts_n;
  logic [7:0]  nxt_rd_data;
  logic [6:0]  rx_trig;
  logic [6:0]  tx_trig;
  logic [6:0]  halt_lvl;
  logic [6:0]  resume_lvl;
  logic [15:0] divisor;
  logic        wr_ev;
  logic        rd_ev;
  logic        iir_rd;
  logic        tbl_wr_ok;
  logic        div_wr;
  logic        thr_cond;
  logic        spc_hit;
  uifr_src_t   src_g;
  logic [5:0]  iid;
  logic        pend;

  assign wr_ev     = reg_req_in.wr;
  assign rd_ev     = reg_req_in.rd;
  assign iir_rd    = rd_ev && hit(reg_req_in, A_IIR);
  assign tbl_wr_ok = efr_ff[EFR_ENH] && mcr_ff[MCR_TLEN];  // [R14] [R17]
  assign div_wr    = wr_ev && (hit(reg_req_in, A_DLL) ||
                               hit(reg_req_in, A_DLH));
  assign divisor   = {dlh_ff, dll_ff};  // [R11]
  assign halt_lvl   = lvl(tcr_ff[3:0]);
  assign resume_lvl = lvl(tcr_ff[7:4]);

  // -------------------------------------------------------------------
  // register writes
  // -------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ier_ff   <= RST_BYTE;
      fcr_ff   <= RST_BYTE;
      mcr_ff   <= RST_BYTE;
      efr_ff   <= RST_BYTE;
      dll_ff   <= RST_BYTE;
      dlh_ff   <= RST_BYTE;
      second_stop_char_ff <= RST_BYTE;
    end else if (wr_ev) begin
      if (hit(reg_req_in, A_IER)) begin
        ier_ff <= prot_wr(ier_ff, reg_req_in.data, IER_PROT,
                          efr_ff[EFR_ENH]);  // [R9]
      end
      if (hit(reg_req_in, A_IIR)) begin
        fcr_ff <= prot_wr(fcr_ff, reg_req_in.data, FCR_PROT,
                          efr_ff[EFR_ENH]) & FCR_KEEP;  // [R9]
      end
      if (hit(reg_req_in, A_MCR)) begin
        mcr_ff <= prot_wr(mcr_ff, reg_req_in.data, MCR_PROT,
                          efr_ff[EFR_ENH]);  // [R9]
      end
      if (hit(reg_req_in, A_EFR)) begin
        efr_ff <= reg_req_in.data;
      end
      if (hit(reg_req_in, A_DLL)) begin
        dll_ff <= reg_req_in.data;  // [R11]
      end
      if (hit(reg_req_in, A_DLH)) begin
        dlh_ff <= reg_req_in.data;  // [R11]
      end
      if (hit(reg_req_in, A_SECOND_STOP_CHAR)) begin
        second_stop_char_ff <= reg_req_in.data;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tcr_ff <= RST_BYTE;
      tlr_ff <= RST_BYTE;
    end else if (wr_ev && tbl_wr_ok) begin
      if (hit(reg_req_in, A_TCR)) begin
        tcr_ff <= reg_req_in.data;  // [R14]
      end
      if (hit(reg_req_in, A_TLR)) begin
        tlr_ff <= reg_req_in.data;  // [R17]
      end
    end
  end

  // -------------------------------------------------------------------
  // trigger levels
  // -------------------------------------------------------------------
  always_comb begin
    if (tlr_ff[7:4] != 4'h0) begin
      rx_trig = lvl(tlr_ff[7:4]);  // [R16] [R18]
    end else if (fcr_ff[FCR_EN]) begin
      rx_trig = FCR_RX_TRIG[fcr_ff[7:6]];  // [R18]
    end else begin
      rx_trig = RX_TRIG_NOFIFO;
    end
    if (tlr_ff[3:0] != 4'h0) begin
      tx_trig = lvl(tlr_ff[3:0]);  // [R16] [R18]
    end else if (fcr_ff[FCR_EN]) begin
      tx_trig = FCR_TX_TRIG[fcr_ff[5:4]];  // [R18]
    end else begin
      tx_trig = 7'(FIFO_DEPTH);
    end
  end

  // -------------------------------------------------------------------
  // sticky interrupt conditions, set wins over clear
  // -------------------------------------------------------------------
  assign thr_cond = (tx_space_in >= tx_trig);
  assign spc_hit  = rx_char_valid_in && efr_ff[EFR_SPC] &&
                    (rx_char_in == second_stop_char_ff);  // [R8]

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      thr_cond_ff <= 1'b0;
      thr_ff      <= 1'b0;
    end else begin
      thr_cond_ff <= thr_cond;
      if (thr_cond && !thr_cond_ff) begin
        thr_ff <= 1'b1;
      end else if (tx_push_in || (iir_rd && iid == ID_THR)) begin
        thr_ff <= 1'b0;  // [R22]
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      xoff_ff <= 1'b0;
    end else if (xoff_rcvd_in || spc_hit) begin
      xoff_ff <= 1'b1;  // [R8]
    end else if (iir_rd && iid == ID_XOFF) begin
      xoff_ff <= 1'b0;  // [R22]
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      cts_ff    <= 1'b0;
      cts_up_ff <= 1'b0;
      rts_up_ff <= 1'b0;
      dcts_ff   <= 1'b0;
    end else begin
      cts_ff <= cts_n_in;
      if (cts_n_in && !cts_ff) begin
        cts_up_ff <= 1'b1;  // [R5]
      end else if (iir_rd && iid == ID_FLOW) begin
        cts_up_ff <= 1'b0;  // [R22]
      end
      if (nxt_rts_n && !rts_n_out) begin
        rts_up_ff <= 1'b1;  // [R5]
      end else if (iir_rd && iid == ID_FLOW) begin
        rts_up_ff <= 1'b0;  // [R22]
      end
      if (cts_n_in != cts_ff) begin
        dcts_ff <= 1'b1;
      end else if (msr_read_in) begin
        dcts_ff <= 1'b0;  // [R22]
      end
    end
  end

  // -------------------------------------------------------------------
  // source gating and identification
  // -------------------------------------------------------------------
  always_comb begin
    src_g.lsr   = line_err_in && ier_ff[IER_LSR];  // [R21]
    src_g.rxto  = rx_timeout_in && ier_ff[IER_RHR];
    src_g.receive_holding   = (rx_fill_in >= rx_trig) && ier_ff[IER_RHR];
    src_g.transmit_holding   = thr_ff && ier_ff[IER_THR];
    src_g.modem = dcts_ff && ier_ff[IER_MOD];
    src_g.xoff  = xoff_ff && ier_ff[IER_XOFF];
    src_g.flow  = (cts_up_ff && ier_ff[IER_CTSI]) ||
                  (rts_up_ff && ier_ff[IER_RTSI]);
  end

  uifr_irq_prio u_prio (
    .src_in   (src_g),
    .iid_out  (iid),   // [R1] [R4] [R5]
    .pend_out (pend)
  );

  // -------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------
  always_comb begin
    nxt_rd_data = RST_BYTE;
    unique case (reg_req_in.addr)
      A_IER:   nxt_rd_data = ier_ff;
      A_IIR:   nxt_rd_data = {{2{fcr_ff[FCR_EN]}}, iid};  // [R2] [R3]
      A_MCR:   nxt_rd_data = mcr_ff;
      A_TCR:   nxt_rd_data = tcr_ff;
      A_TLR:   nxt_rd_data = tlr_ff;
      A_TX_FIFO_SPACE_COUNT: nxt_rd_data = {1'b0, tx_space_in};  // [R20]
      A_DLL:   nxt_rd_data = dll_ff;
      A_DLH:   nxt_rd_data = dlh_ff;
      A_EFR:   nxt_rd_data = efr_ff;
      A_SECOND_STOP_CHAR: nxt_rd_data = second_stop_char_ff;
      default: nxt_rd_data = RST_BYTE;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rd_data_out <= RST_BYTE;
    end else if (rd_ev) begin
      rd_data_out <= nxt_rd_data;
    end
  end

  // -------------------------------------------------------------------
  // auto rts hysteresis and cts gate
  // -------------------------------------------------------------------
  always_comb begin
    nxt_rts_st = rts_st_ff;
    if (!efr_ff[EFR_RTS]) begin
      nxt_rts_st = RTS_GO;
    end else begin
      unique case (rts_st_ff)
        RTS_GO: begin
          if (rx_fill_in >= halt_lvl) begin
            nxt_rts_st = RTS_HALT;  // [R7]
          end
        end
        RTS_HALT: begin
          if (rx_fill_in <= resume_lvl) begin
            nxt_rts_st = RTS_GO;  // [R7]
          end
        end
      endcase
    end
    nxt_rts_n = efr_ff[EFR_RTS] ? (nxt_rts_st == RTS_HALT)
                                : !mcr_ff[MCR_RTS];
  end

  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      rts_st_ff       <= RTS_GO;
      rts_n_out       <= 1'b1;
      tx_halt_out     <= 1'b0;
      irq_n_out       <= 1'b1;
      sw_flow_sel_out <= 4'h0;
    end else begin
      rts_st_ff       <= nxt_rts_st;
      rts_n_out       <= nxt_rts_n;  // [R7]
      tx_halt_out     <= efr_ff[EFR_CTS] && cts_n_in;  // [R6]
      irq_n_out       <= !pend;  // [R21]
      sw_flow_sel_out <= efr_ff[3:0];  // [R10]
    end
  end

  // -------------------------------------------------------------------
  // baud divider
  // -------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      baud_cnt_ff   <= RST_CNT;
      baud_tick_out <= 1'b0;
    end else begin
      if (div_wr || baud_cnt_ff >= divisor - ONE16) begin
        baud_cnt_ff <= RST_CNT;
      end else begin
        baud_cnt_ff <= baud_cnt_ff + ONE16;
      end
      baud_tick_out <= !div_wr && (divisor != RST_CNT) &&
                       (baud_cnt_ff == divisor - ONE16);  // [R11]
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_ff);

  a_iir_fifo_mirror: assert property (  // [R2]
    iir_rd |=> rd_data_out[7:6] == {2{$past(fcr_ff[FCR_EN])}})
    else $error("id bits 7:6 do not mirror fifo enable");
  a_iir_none_bit: assert property (  // [R3]
    iir_rd |=> rd_data_out[0] == !$past(pend))
    else $error("id bit 0 wrong for pending state");
  a_lsr_first: assert property (  // [R4]
    iir_rd && src_g.lsr |=> rd_data_out[5:0] == ID_LSR)
    else $error("line error not reported first");
  a_flow_lowest: assert property (  // [R5]
    iir_rd && src_g.flow && !(src_g.lsr || src_g.rxto || src_g.receive_holding ||
      src_g.transmit_holding || src_g.modem || src_g.xoff)
    |=> rd_data_out[5:0] == ID_FLOW)
    else $error("flow change code wrong");
  a_cts_off: assert property (  // [R6]
    !efr_ff[EFR_CTS] [*2] |-> !tx_halt_out)
    else $error("cts gates transmit while disabled");
  a_rts_halt: assert property (  // [R7]
    efr_ff[EFR_RTS] && rx_fill_in >= halt_lvl |=> rts_n_out)
    else $error("rts not raised at halt level");
  a_spc_flag: assert property (  // [R8]
    spc_hit && ier_ff[IER_XOFF] |=> src_g.xoff)
    else $error("special character not flagged");
  a_ier_guard: assert property (  // [R9]
    wr_ev && hit(reg_req_in, A_IER) && !efr_ff[EFR_ENH]
    |=> ier_ff[7:4] == $past(ier_ff[7:4]))
    else $error("protected enable bits written");
  a_tcr_guard: assert property (  // [R14]
    wr_ev && hit(reg_req_in, A_TCR) && !tbl_wr_ok |=> $stable(tcr_ff))
    else $error("flow threshold written while locked");
  a_tlr_guard: assert property (  // [R17]
    wr_ev && hit(reg_req_in, A_TLR) && !tbl_wr_ok |=> $stable(tlr_ff))
    else $error("trigger levels written while locked");
  a_trig_fallback: assert property (  // [R18]
    tlr_ff[7:4] == 4'h0 && fcr_ff[FCR_EN]
    |-> rx_trig == FCR_RX_TRIG[fcr_ff[7:6]])
    else $error("zero trigger field not falling back");
  a_tx_fifo_space_count_top: assert property (  // [R20]
    rd_ev && hit(reg_req_in, A_TX_FIFO_SPACE_COUNT) |=> !rd_data_out[7])
    else $error("space count bit 7 set");
  a_irq_quiet: assert property (  // [R21]
    (src_g == '0) [*2] |-> irq_n_out)
    else $error("interrupt without enabled source");

endmodule : uifr_regs
`default_nettype wire

/* File: tb/uifr_far_model.sv */
// far-side model: fifo levels, line events and cts pin
`timescale 1ns/100ps
`default_nettype none
module uifr_far_model (
  input  wire logic       clk_in,
  output logic [6:0]      rx_fill_out,
  output logic [6:0]      tx_space_out,
  output logic            line_err_out,
  output logic            timeout_out,
  output logic            cts_n_out,
  output logic            char_vld_out,
  output logic            xoff_out,
  output logic [7:0]      char_out
);
  initial begin
    {rx_fill_out, tx_space_out} = {7'h00, 7'h40};
    {line_err_out, timeout_out, cts_n_out} = 3'h0;
    {char_vld_out, xoff_out, char_out} = 10'h000;
  end
  // levels change after an edge, then settle three cycles
  task automatic lvl(input logic [6:0] rx, input logic [6:0] tx,
                     input logic le, input logic to, input logic cts);
    @(posedge clk_in);
    rx_fill_out <= rx;
    tx_space_out <= tx;
    {line_err_out, timeout_out, cts_n_out} <= {le, to, cts};
    repeat (3) @(posedge clk_in);
    #1;
  endtask : lvl
  // one-cycle pulse: xoff when x is set, else a stored character
  task automatic chr(input logic x, input logic [7:0] c);
    @(posedge clk_in);
    xoff_out <= x;
    char_vld_out <= ~x;
    char_out <= c;
    @(posedge clk_in);
    {xoff_out, char_vld_out} <= 2'h0;
  endtask : chr
endmodule : uifr_far_model
`default_nettype wire

/* File: tb/tb_top.sv */
// self-checking bench of the uart register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import uifr_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  uifr_req_t  req = '0;
  logic [7:0] rdat, ch;
  logic [6:0] rxf, txs;
  logic       ler, tmo, cts_n, cv, xo, rts_n, halt, irq_n, tick;
  logic [3:0] swf;
  int         num_errors = 0;
  int         checks = 0;
  always #50 clk = ~clk;
  uifr_far_model far (.clk_in(clk), .rx_fill_out(rxf), .tx_space_out(txs),
    .line_err_out(ler), .timeout_out(tmo), .cts_n_out(cts_n),
    .char_vld_out(cv), .xoff_out(xo), .char_out(ch));
  uifr_regs #(.FIFO_DEPTH(64)) dut (.clock_in(clk), .arst_n_in(rst_n),
    .reg_req_in(req), .rd_data_out(rdat), .rx_fill_in(rxf),
    .tx_space_in(txs), .line_err_in(ler), .rx_timeout_in(tmo),
    .rx_char_valid_in(cv), .rx_char_in(ch), .xoff_rcvd_in(xo),
    .tx_push_in(1'b0), .msr_read_in(1'b0), .cts_n_in(cts_n),
    .rts_n_out(rts_n), .tx_halt_out(halt), .irq_n_out(irq_n),
    .baud_tick_out(tick), .sw_flow_sel_out(swf));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    @(posedge clk);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 chk(rdat, e);
  endtask : rd
  task automatic give_verdict;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #200000;
    num_errors++;
    give_verdict();
  end
  initial begin
    int n;
    n = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(A_IIR, 8'h01);
    rd(4'hF, 8'h00);
    wr(A_IER, 8'hF7);
    wr(A_MCR, 8'h04);
    wr(A_TCR, 8'h24);
    rd(A_IER, 8'h07);
    rd(A_TCR, 8'h00);
    wr(A_EFR, 8'h10);
    wr(A_MCR, 8'h04);
    wr(A_TCR, 8'h24); // halt above resume
    wr(A_TLR, 8'h21);
    rd(A_TCR, 8'h24);
    rd(A_TLR, 8'h21);
    wr(A_IIR, 8'h01); // bits 7:6 left 00
    wr(A_IER, 8'h27);
    rd(A_IIR, 8'hC2);
    far.lvl(7'h00, 7'h40, 1'b1, 1'b0, 1'b0);
    chk({7'h00, irq_n}, 8'h00);
    rd(A_IIR, 8'hC6);
    far.lvl(7'h00, 7'h40, 1'b0, 1'b1, 1'b0);
    rd(A_IIR, 8'hCC);
    far.lvl(7'h08, 7'h40, 1'b0, 1'b0, 1'b0);
    rd(A_IIR, 8'hC4);
    far.lvl(7'h07, 7'h02, 1'b0, 1'b0, 1'b0);
    far.lvl(7'h07, 7'h40, 1'b0, 1'b0, 1'b0);
    rd(A_IIR, 8'hC2);
    rd(A_IIR, 8'hC1);
    far.lvl(7'h07, 7'h25, 1'b0, 1'b0, 1'b0);
    chk({7'h00, irq_n}, 8'h01);
    rd(A_TX_FIFO_SPACE_COUNT, 8'h25);
    far.chr(1'b1, 8'h00);
    rd(A_IIR, 8'hD0);
    rd(A_IIR, 8'hC1);
    wr(A_EFR, 8'h30);
    wr(A_SECOND_STOP_CHAR, 8'h13);
    far.chr(1'b0, 8'h14);
    far.chr(1'b0, 8'h13);
    rd(A_IIR, 8'hD0);
    rd(A_IIR, 8'hC1);
    wr(A_EFR, 8'h9A);
    far.lvl(7'h07, 7'h25, 1'b0, 1'b0, 1'b1);
    chk({7'h00, halt}, 8'h01);
    chk({4'h0, swf}, 8'h0A);
    wr(A_EFR, 8'h1A);
    far.lvl(7'h07, 7'h25, 1'b0, 1'b0, 1'b1);
    chk({7'h00, halt}, 8'h00);
    wr(A_EFR, 8'h50);
    far.lvl(7'h07, 7'h25, 1'b0, 1'b0, 1'b1);
    chk({7'h00, rts_n}, 8'h00);
    far.lvl(7'h10, 7'h25, 1'b0, 1'b0, 1'b1);
    chk({7'h00, rts_n}, 8'h01);
    far.lvl(7'h0C, 7'h25, 1'b0, 1'b0, 1'b1);
    chk({7'h00, rts_n}, 8'h01);
    far.lvl(7'h08, 7'h25, 1'b0, 1'b0, 1'b1);
    chk({7'h00, rts_n}, 8'h00);
    wr(A_DLL, 8'h03); // sleep mode still off
    repeat (30) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1) n++;
    end
    chk(n[7:0], 8'h0A);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
